// file: src/cad_decoder.sv
// Purpose: Operand fetch and effective-address sequencer of an 8-bit core.
// Assumes: Memory answers each one-cycle read strobe with a one-cycle valid, later.
// Notes: Opcode values are decoded elsewhere; this block receives the mode class.

// Contract
// RULE1: Immediate mode fetches one byte and uses it as the operand value.
// RULE2: Short direct reads one address byte; address within 00 to ff.
// RULE3: Long direct reads a two-byte address reaching all 64 Kbyte.
// RULE4: Indexed address is unsigned sum of X or Y and the offset.
// RULE5: No-offset indexed fetches nothing; index alone is the address.
// RULE6: Short indexed adds one offset byte keeping carry, up to 1fe.
// RULE7: Long indexed adds a two-byte offset word to the index.
// RULE8: Indirect reads the pointer from memory at the byte after opcode.
// RULE9: Short indirect pointer is one byte, address within 00 to ff.
// RULE10: Long indirect forms read a two-byte pointer through a one-byte address.
// RULE11: Indirect-indexed address is index plus pointer read from memory.
// RULE12: Short indirect-indexed yields addresses 00 to 1fe, one byte after opcode.
// RULE13: Relative target is counter plus sign-extended 8-bit offset.
// RULE14: Direct relative takes the offset from the byte after the opcode.
// RULE15: Indirect relative reads the offset from memory at the following address.
// RULE16: The decoder accepts 63 distinct instruction types.
// RULE17: Inherent instructions are one byte with no operand fetch.
// RULE18: Read-modify-write instructions accept only short address forms.
// RULE19: Prefix 90 swaps X for Y in immediate, direct, indexed, inherent.
// RULE20: Prefix 92 turns direct and X indexed forms into indirect forms.
// RULE21: Multi-byte words take the first fetched byte as high byte.
module cad_decoder #(
  parameter int unsigned NUM_TYPES = cad_pkg::NUM_INSTR_TYPES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire cad_pkg::cad_mode_t mode_i,
  input wire logic [cad_pkg::TYPE_W-1:0] instr_type_i,
  input wire logic rmw_i,
  input wire logic prefix_valid_i,
  input wire logic [7:0] prefix_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output cad_pkg::cad_mode_t mode_o,
  output logic use_y_o,
  output logic [2:0] len_o,
  output logic [7:0] operand_o,
  output logic [15:0] ea_o,
  output logic [15:0] target_o
);

  if (NUM_TYPES < 1 || NUM_TYPES >= (1 << cad_pkg::TYPE_W))
  begin : g_bad_types
    $error("NUM_TYPES does not fit the instruction type field");
  end

  localparam logic [cad_pkg::TYPE_W-1:0] TYPE_LIMIT = cad_pkg::TYPE_W'(NUM_TYPES);

  typedef struct packed {
    cad_pkg::cad_state_t st;
    logic busy;
    cad_pkg::cad_mode_t mode;
    logic use_y;
    logic [1:0] cnt;
    logic pend;
    logic [15:0] acc;
    logic [15:0] fetch;
    logic [15:0] pc_end;
    logic [7:0] idx;
    logic mem_rd;
    logic [15:0] mem_addr;
    logic done;
    logic illegal;
    logic [2:0] len;
    logic [7:0] operand;
    logic [15:0] ea;
    logic [15:0] target;
  } cad_regs_t;

  cad_regs_t s;
  cad_regs_t next_s;

  logic [15:0] calc_ea;
  logic [15:0] calc_target;

  cad_ea_calc u_calc (
    .mode_i(s.mode),
    .idx_i(s.idx),
    .acc_i(s.acc),
    .pc_end_i(s.pc_end),
    .ea_o(calc_ea),
    .target_o(calc_target)
  );

  // Operand bytes that follow the opcode for each mode.
  function automatic logic [1:0] cad_opnd_bytes(input cad_pkg::cad_mode_t m);
    case (m)
      cad_pkg::CAD_INH: cad_opnd_bytes = 2'h0; // RULE17
      cad_pkg::CAD_IDX_0: cad_opnd_bytes = 2'h0; // RULE5
      cad_pkg::CAD_DIR_L: cad_opnd_bytes = 2'h2; // RULE3
      cad_pkg::CAD_IDX_L: cad_opnd_bytes = 2'h2; // RULE7
      // Pointer forms keep a single pointer-address byte after the opcode.
      default: cad_opnd_bytes = 2'h1; // RULE1 RULE2 RULE6 RULE10 RULE12 RULE14
    endcase
  endfunction : cad_opnd_bytes

  // Bytes read through the pointer for indirect modes.
  function automatic logic [1:0] cad_ptr_bytes(input cad_pkg::cad_mode_t m);
    case (m)
      cad_pkg::CAD_IND_S: cad_ptr_bytes = 2'h1; // RULE9
      cad_pkg::CAD_IIX_S: cad_ptr_bytes = 2'h1; // RULE12
      cad_pkg::CAD_REL_I: cad_ptr_bytes = 2'h1; // RULE15
      cad_pkg::CAD_IND_L: cad_ptr_bytes = 2'h2; // RULE10
      cad_pkg::CAD_IIX_L: cad_ptr_bytes = 2'h2; // RULE10
      default: cad_ptr_bytes = 2'h0;
    endcase
  endfunction : cad_ptr_bytes

  function automatic logic cad_is_long(input cad_pkg::cad_mode_t m);
    cad_is_long = (m == cad_pkg::CAD_DIR_L) || (m == cad_pkg::CAD_IDX_L) ||
                  (m == cad_pkg::CAD_IND_L) || (m == cad_pkg::CAD_IIX_L);
  endfunction : cad_is_long

  cad_pkg::cad_mode_t eff_mode;
  logic pfx_y;
  logic pfx_ind;
  logic bad_req;

  always_comb
  begin
    pfx_y = prefix_valid_i && (prefix_i == cad_pkg::Y_SELECT_PREFIX);
    pfx_ind = prefix_valid_i && (prefix_i == cad_pkg::INDIRECT_SELECT_PREFIX);
    eff_mode = mode_i;
    if (pfx_ind)
    begin
      case (mode_i)
        cad_pkg::CAD_DIR_S: eff_mode = cad_pkg::CAD_IND_S; // RULE20
        cad_pkg::CAD_DIR_L: eff_mode = cad_pkg::CAD_IND_L; // RULE20
        cad_pkg::CAD_IDX_S: eff_mode = cad_pkg::CAD_IIX_S; // RULE20
        cad_pkg::CAD_IDX_L: eff_mode = cad_pkg::CAD_IIX_L; // RULE20
        cad_pkg::CAD_REL_D: eff_mode = cad_pkg::CAD_REL_I; // RULE20
        default: eff_mode = mode_i;
      endcase
    end
    // Unknown types and long read-modify-write forms are refused, not guessed.
    bad_req = (instr_type_i >= TYPE_LIMIT) || (rmw_i && cad_is_long(eff_mode)); // RULE16 RULE18
  end

  always_comb
  begin
    next_s = s;
    next_s.mem_rd = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      cad_pkg::CAD_IDLE:
      begin
        if (start_i)
        begin
          next_s.mode = eff_mode;
          next_s.use_y = pfx_y; // RULE19
          next_s.idx = pfx_y ? y_i : x_i; // RULE19
          next_s.cnt = cad_opnd_bytes(eff_mode);
          next_s.acc = cad_pkg::RESET_ADDR;
          next_s.fetch = pc_i + 16'h0001;
          next_s.pc_end = pc_i + 16'h0001;
          next_s.pend = 1'b0;
          next_s.illegal = bad_req;
          next_s.len = cad_pkg::OPCODE_LEN + {2'b00, prefix_valid_i} +
                       {1'b0, cad_opnd_bytes(eff_mode)};
          next_s.st = (bad_req || cad_opnd_bytes(eff_mode) == 2'h0) ? cad_pkg::CAD_FIN :
                      cad_pkg::CAD_OPND;
        end
      end
      cad_pkg::CAD_OPND, cad_pkg::CAD_PTR:
      begin
        if (!s.pend)
        begin
          next_s.mem_rd = 1'b1;
          next_s.mem_addr = s.fetch;
          next_s.pend = 1'b1;
        end
        else if (mem_rvalid_i)
        begin
          next_s.pend = 1'b0;
          next_s.acc = {s.acc[7:0], mem_rdata_i}; // RULE21
          next_s.fetch = s.fetch + 16'h0001;
          next_s.cnt = s.cnt - 2'h1;
          if (s.st == cad_pkg::CAD_OPND)
            next_s.pc_end = s.fetch + 16'h0001;
          if (s.cnt == 2'h1)
          begin
            if (s.st == cad_pkg::CAD_OPND && cad_ptr_bytes(s.mode) != 2'h0)
            begin
              next_s.st = cad_pkg::CAD_PTR;
              next_s.cnt = cad_ptr_bytes(s.mode);
              next_s.fetch = {8'h00, mem_rdata_i}; // RULE8
              next_s.acc = cad_pkg::RESET_ADDR;
            end
            else
              next_s.st = cad_pkg::CAD_FIN;
          end
        end
      end
      cad_pkg::CAD_FIN:
      begin
        next_s.done = 1'b1;
        next_s.st = cad_pkg::CAD_IDLE;
        // Immediate data is the fetched byte itself, with no further read.
        next_s.operand = (s.mode == cad_pkg::CAD_IMM) ? s.acc[7:0] : cad_pkg::RESET_BYTE; // RULE1
        next_s.ea = calc_ea;
        next_s.target = calc_target; // RULE13
      end
      default: next_s.st = cad_pkg::CAD_IDLE;
    endcase
    // Registered so that the busy output leaves a flip-flop with no gate after it.
    next_s.busy = (next_s.st != cad_pkg::CAD_IDLE);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign mem_rd_o = s.mem_rd;
  assign mem_addr_o = s.mem_addr;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign illegal_o = s.illegal;
  assign mode_o = s.mode;
  assign use_y_o = s.use_y;
  assign len_o = s.len;
  assign operand_o = s.operand;
  assign ea_o = s.ea;
  assign target_o = s.target;

  // Helper logic for the checks below: reads per instruction and the first byte.
  logic [2:0] rd_count;
  logic [7:0] first_byte;
  logic first_seen;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_count <= 3'h0;
      first_byte <= 8'h00;
      first_seen <= 1'b0;
    end
    else if (s.st == cad_pkg::CAD_IDLE && start_i)
    begin
      rd_count <= 3'h0;
      first_seen <= 1'b0;
    end
    else
    begin
      if (s.mem_rd)
        rd_count <= rd_count + 3'h1;
      if (s.pend && mem_rvalid_i && !first_seen)
      begin
        first_byte <= mem_rdata_i;
        first_seen <= 1'b1;
      end
    end
  end

  property p_imm_one_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && !illegal_o && mode_o == cad_pkg::CAD_IMM) |-> (rd_count == 3'h1);
  endproperty
  a_imm_one_read: assert property (p_imm_one_read) else $error("imm read count wrong"); // RULE1
  property p_short_page0;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && (mode_o == cad_pkg::CAD_DIR_S || mode_o == cad_pkg::CAD_IND_S))
      |-> (ea_o <= cad_pkg::PAGE0_MAX);
  endproperty
  a_short_page0: assert property (p_short_page0) else $error("short address left page 0"); // RULE2
  property p_long_dir_hi;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && !illegal_o && mode_o == cad_pkg::CAD_DIR_L)
      |-> (rd_count == 3'h2 && ea_o[15:8] == first_byte);
  endproperty
  a_long_dir_hi: assert property (p_long_dir_hi) else $error("long direct word wrong"); // RULE3
  property p_idx0_ea;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && mode_o == cad_pkg::CAD_IDX_0)
      |-> (rd_count == 3'h0 && ea_o == {8'h00, s.idx});
  endproperty
  a_idx0_ea: assert property (p_idx0_ea) else $error("no-offset index address wrong"); // RULE5
  property p_short_idx_max;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && (mode_o == cad_pkg::CAD_IDX_S || mode_o == cad_pkg::CAD_IIX_S))
      |-> (ea_o <= cad_pkg::SHORT_IDX_MAX);
  endproperty
  a_short_idx_max: assert property (p_short_idx_max) else $error("short index overflow"); // RULE6
  property p_long_ind_reads;
    @(posedge clk_sys_i) disable iff (rst_i)
    (done_o && !illegal_o && (mode_o == cad_pkg::CAD_IND_L || mode_o == cad_pkg::CAD_IIX_L))
      |-> (rd_count == 3'h3);
  endproperty
  a_long_ind_reads: assert property (p_long_ind_reads) else $error("long pointer reads wrong"); // RULE10
  property p_ptr_page0;
    @(posedge clk_sys_i) disable iff (rst_i)
    (mem_rd_o && s.st == cad_pkg::CAD_PTR && s.cnt == cad_ptr_bytes(s.mode))
      |-> (mem_addr_o[15:8] == 8'h00);
  endproperty
  a_ptr_page0: assert property (p_ptr_page0) else $error("pointer address above page 0"); // RULE8
  property p_rel_target;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s.st == cad_pkg::CAD_FIN && (s.mode == cad_pkg::CAD_REL_D || s.mode == cad_pkg::CAD_REL_I))
      |=> (target_o == $past(s.pc_end) + {{8{$past(s.acc[7])}}, $past(s.acc[7:0])});
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target wrong"); // RULE13
  property p_inh_no_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s.st == cad_pkg::CAD_IDLE && start_i && !bad_req && eff_mode == cad_pkg::CAD_INH)
      |-> ##1 (!mem_rd_o) [*2] ##0 done_o;
  endproperty
  a_inh_no_read: assert property (p_inh_no_read) else $error("inherent fetched a byte"); // RULE17
  property p_refuse;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s.st == cad_pkg::CAD_IDLE && start_i && bad_req) |-> ##2 (done_o && illegal_o);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad request not refused"); // RULE16 RULE18
  property p_y_prefix;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s.st == cad_pkg::CAD_IDLE && start_i && pfx_y) |=> (use_y_o && s.idx == $past(y_i));
  endproperty
  a_y_prefix: assert property (p_y_prefix) else $error("y prefix not applied"); // RULE19

endmodule : cad_decoder

// file: src/cad_ea_calc.sv
// Purpose: Combinational effective-address and branch-target arithmetic.
// Assumes: Operand word and index already gathered by the sequencer.
// Notes: All sums are 16 bits wide and wrap at the top of memory.
module cad_ea_calc (
  input wire cad_pkg::cad_mode_t mode_i,
  input wire logic [7:0] idx_i,
  input wire logic [15:0] acc_i,
  input wire logic [15:0] pc_end_i,
  output logic [15:0] ea_o,
  output logic [15:0] target_o
);

  logic [15:0] idx_w;
  logic [15:0] low_w;

  assign idx_w = {8'h00, idx_i};
  assign low_w = {8'h00, acc_i[7:0]};

  always_comb
  begin
    case (mode_i)
      cad_pkg::CAD_DIR_S: ea_o = low_w; // RULE2
      cad_pkg::CAD_DIR_L: ea_o = acc_i; // RULE3
      cad_pkg::CAD_IDX_0: ea_o = idx_w; // RULE5
      // The carry is kept so short forms reach up to 1fe.
      cad_pkg::CAD_IDX_S: ea_o = low_w + idx_w; // RULE4 RULE6
      cad_pkg::CAD_IDX_L: ea_o = acc_i + idx_w; // RULE7
      cad_pkg::CAD_IND_S: ea_o = low_w; // RULE9
      cad_pkg::CAD_IND_L: ea_o = acc_i; // RULE10
      cad_pkg::CAD_IIX_S: ea_o = low_w + idx_w; // RULE11 RULE12
      cad_pkg::CAD_IIX_L: ea_o = acc_i + idx_w; // RULE11
      default: ea_o = cad_pkg::RESET_ADDR;
    endcase
  end

  // The offset is sign-extended from bit 7 before it meets the counter.
  assign target_o = pc_end_i + {{8{acc_i[7]}}, acc_i[7:0]}; // RULE13

endmodule : cad_ea_calc

// file: src/cad_pkg.sv
// Purpose: Shared constants and types for the addressing-mode decoder.
// Assumes: 8-bit data, 16-bit address, one core clock.
// Notes: Mode codes are local to this block, not opcode values.
package cad_pkg;

  localparam int unsigned NUM_INSTR_TYPES = 63;
  localparam int unsigned TYPE_W = 6;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] Y_SELECT_PREFIX = 8'h90;
  localparam logic [7:0] INDIRECT_SELECT_PREFIX = 8'h92;

  localparam logic [15:0] PAGE0_MAX = 16'h00ff;
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01fe;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Bytes of the opcode itself; the decoder adds one more for a prefix before the operand bytes.
  localparam logic [2:0] OPCODE_LEN = 3'h1;

  typedef enum logic [3:0] {
    CAD_INH   = 4'h0,
    CAD_IMM   = 4'h1,
    CAD_DIR_S = 4'h2,
    CAD_DIR_L = 4'h3,
    CAD_IDX_0 = 4'h4,
    CAD_IDX_S = 4'h5,
    CAD_IDX_L = 4'h6,
    CAD_IND_S = 4'h7,
    CAD_IND_L = 4'h8,
    CAD_IIX_S = 4'h9,
    CAD_IIX_L = 4'ha,
    CAD_REL_D = 4'hb,
    CAD_REL_I = 4'hc
  } cad_mode_t;

  typedef enum logic [1:0] {
    CAD_IDLE = 2'h0,
    CAD_OPND = 2'h1,
    CAD_PTR  = 2'h3,
    CAD_FIN  = 2'h2
  } cad_state_t;

endpackage : cad_pkg

// file: verification/cad_decoder_test.sv
// Purpose: Self-checking bench for the addressing-mode sequencer.
// Assumes: Memory model on the far side, one 20 MHz clock.
// Notes: Expected addresses are worked out from the bytes poked into memory.
module cad_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  cad_pkg::cad_mode_t mode_i = cad_pkg::CAD_INH;
  logic [5:0] instr_type_i = 6'h00;
  logic rmw_i = 1'b0;
  logic prefix_valid_i = 1'b0;
  logic [7:0] prefix_i = 8'h00;
  logic [15:0] pc_i = 16'h0000;
  logic [7:0] x_i = 8'h00;
  logic [7:0] y_i = 8'h00;
  logic [3:0] lat = 4'h1;
  logic [7:0] mem_rdata_i;
  logic mem_rvalid_i, mem_rd_o, busy_o, done_o, illegal_o, use_y_o;
  logic [15:0] mem_addr_o, ea_o, target_o;
  cad_pkg::cad_mode_t mode_o;
  logic [2:0] len_o;
  logic [7:0] operand_o;
  int error_cnt = 0;
  int comparisons = 0;
  int rd_cnt = 0;
  logic busy_seen = 1'b0;
  int lat_n = 0;
  int cyc = 0;

  cad_decoder dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i),
    .instr_type_i(instr_type_i), .rmw_i(rmw_i), .prefix_valid_i(prefix_valid_i),
    .prefix_i(prefix_i), .pc_i(pc_i), .x_i(x_i), .y_i(y_i), .mem_rdata_i(mem_rdata_i),
    .mem_rvalid_i(mem_rvalid_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .mode_o(mode_o),
    .use_y_o(use_y_o), .len_o(len_o), .operand_o(operand_o), .ea_o(ea_o),
    .target_o(target_o));
  cad_mem_model u_mem (.clk_i(clk_sys_i), .rst_i(rst_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .lat_i(lat), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i));

  always #25 clk_sys_i = ~clk_sys_i;

  // Strobes are counted at the falling edge, where the registered outputs are settled.
  always @(negedge clk_sys_i)
  begin
    if (mem_rd_o === 1'b1)
    begin
      rd_cnt++;
    end
  end

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    u_mem.mem[a] = v;
  endtask : poke

  task automatic run(input cad_pkg::cad_mode_t m, input logic [7:0] pf, input logic [5:0] ty,
    input logic rw, input logic [15:0] pc, input logic [7:0] xv, input logic [7:0] yv);
    @(posedge clk_sys_i);
    mode_i <= m;
    prefix_valid_i <= (pf != 8'h00);
    prefix_i <= pf;
    instr_type_i <= ty;
    rmw_i <= rw;
    pc_i <= pc;
    x_i <= xv;
    y_i <= yv;
    start_i <= 1'b1;
    rd_cnt = 0;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    lat_n = 0;
    while (done_o !== 1'b1 && lat_n < 80)
    begin
      @(negedge clk_sys_i);
      lat_n++;
      if (lat_n == 1)
        busy_seen = busy_o;
    end
    check(done_o, 1'b1);
  endtask : run

  task automatic t_inh();
    run(cad_pkg::CAD_INH, 8'h00, 6'h01, 1'b0, 16'h1000, 8'h00, 8'h00);
    check(lat_n, 2);
    check(rd_cnt, 0);
    check(len_o, 3'h1);
    check(busy_seen, 1'b1);
    check(busy_o, 1'b0);
    run(cad_pkg::CAD_INH, 8'h90, 6'h02, 1'b0, 16'h1000, 8'h00, 8'h00);
    check(use_y_o, 1'b1);
    check(len_o, 3'h2);
    run(cad_pkg::CAD_INH, 8'h91, 6'h02, 1'b0, 16'h1000, 8'h00, 8'h00);
    check(use_y_o, 1'b0);
    check(mode_o, cad_pkg::CAD_INH);
  endtask : t_inh

  task automatic t_imm_dir();
    poke(16'h2001, 8'h3c);
    run(cad_pkg::CAD_IMM, 8'h90, 6'h03, 1'b0, 16'h2000, 8'h00, 8'h00);
    check(operand_o, 8'h3c);
    check(rd_cnt, 1);
    check(use_y_o, 1'b1);
    poke(16'h3001, 8'hc7);
    run(cad_pkg::CAD_DIR_S, 8'h00, 6'h04, 1'b0, 16'h3000, 8'h00, 8'h00);
    check(ea_o, 16'h00c7);
    check(len_o, 3'h2);
    poke(16'h4001, 8'h12);
    poke(16'h4002, 8'h34);
    run(cad_pkg::CAD_DIR_L, 8'h00, 6'h05, 1'b0, 16'h4000, 8'h00, 8'h00);
    check(ea_o, 16'h1234);
    check(rd_cnt, 2);
    check(len_o, 3'h3);
  endtask : t_imm_dir

  task automatic t_idx();
    run(cad_pkg::CAD_IDX_0, 8'h00, 6'h06, 1'b0, 16'h5000, 8'hff, 8'h00);
    check(ea_o, 16'h00ff);
    check(rd_cnt, 0);
    poke(16'h5101, 8'hff);
    run(cad_pkg::CAD_IDX_S, 8'h00, 6'h07, 1'b0, 16'h5100, 8'hff, 8'h01);
    check(ea_o, 16'h01fe);
    poke(16'h6001, 8'hab);
    poke(16'h6002, 8'hf8);
    run(cad_pkg::CAD_IDX_L, 8'h90, 6'h08, 1'b0, 16'h6000, 8'h01, 8'h10);
    check(ea_o, 16'hac08);
    check(len_o, 3'h4);
  endtask : t_idx

  task automatic t_ind();
    poke(16'h7001, 8'h40);
    poke(16'h0040, 8'h9a);
    run(cad_pkg::CAD_DIR_S, 8'h92, 6'h09, 1'b0, 16'h7000, 8'h00, 8'h00);
    check(mode_o, cad_pkg::CAD_IND_S);
    check(ea_o, 16'h009a);
    check(rd_cnt, 2);
    lat = 4'h3;
    poke(16'h7101, 8'h50);
    poke(16'h0050, 8'hde);
    poke(16'h0051, 8'had);
    run(cad_pkg::CAD_IND_L, 8'h00, 6'h0a, 1'b0, 16'h7100, 8'h00, 8'h00);
    check(ea_o, 16'hdead);
    check(len_o, 3'h2);
    lat = 4'h1;
    poke(16'h7201, 8'h60);
    poke(16'h0060, 8'hff);
    run(cad_pkg::CAD_IIX_S, 8'h00, 6'h0b, 1'b0, 16'h7200, 8'hff, 8'h00);
    check(ea_o, 16'h01fe);
    poke(16'h7301, 8'h70);
    poke(16'h0070, 8'h12);
    poke(16'h0071, 8'hf0);
    run(cad_pkg::CAD_IDX_L, 8'h92, 6'h0c, 1'b0, 16'h7300, 8'h20, 8'h00);
    check(mode_o, cad_pkg::CAD_IIX_L);
    check(ea_o, 16'h1310);
    check(rd_cnt, 3);
    poke(16'h7401, 8'h80);
    poke(16'h0080, 8'h10);
    run(cad_pkg::CAD_IDX_S, 8'h92, 6'h0c, 1'b0, 16'h7400, 8'h05, 8'h00);
    check(mode_o, cad_pkg::CAD_IIX_S);
    check(ea_o, 16'h0015);
    poke(16'h7501, 8'ha0);
    poke(16'h00a0, 8'h12);
    poke(16'h00a1, 8'h34);
    run(cad_pkg::CAD_DIR_L, 8'h92, 6'h0c, 1'b0, 16'h7500, 8'h00, 8'h00);
    check(mode_o, cad_pkg::CAD_IND_L);
    check(ea_o, 16'h1234);
    check(rd_cnt, 3);
  endtask : t_ind

  task automatic t_rel();
    poke(16'h8001, 8'h80);
    run(cad_pkg::CAD_REL_D, 8'h00, 6'h0d, 1'b0, 16'h8000, 8'h00, 8'h00);
    check(target_o, 16'h7f82);
    poke(16'h8101, 8'h7f);
    run(cad_pkg::CAD_REL_D, 8'h00, 6'h0d, 1'b0, 16'h8100, 8'h00, 8'h00);
    check(target_o, 16'h8181);
    poke(16'h8201, 8'h90);
    poke(16'h0090, 8'hfe);
    run(cad_pkg::CAD_REL_D, 8'h92, 6'h0e, 1'b0, 16'h8200, 8'h00, 8'h00);
    check(mode_o, cad_pkg::CAD_REL_I);
    check(target_o, 16'h8200);
    check(rd_cnt, 2);
  endtask : t_rel

  task automatic t_refuse();
    run(cad_pkg::CAD_DIR_L, 8'h00, 6'h3f, 1'b0, 16'h4000, 8'h00, 8'h00);
    check(illegal_o, 1'b1);
    check(rd_cnt, 0);
    check(lat_n, 2);
    run(cad_pkg::CAD_INH, 8'h00, 6'h3e, 1'b0, 16'h1000, 8'h00, 8'h00);
    check(illegal_o, 1'b0);
    run(cad_pkg::CAD_DIR_L, 8'h00, 6'h10, 1'b1, 16'h4000, 8'h00, 8'h00);
    check(illegal_o, 1'b1);
    check(rd_cnt, 0);
    run(cad_pkg::CAD_DIR_S, 8'h00, 6'h10, 1'b1, 16'h3000, 8'h00, 8'h00);
    check(illegal_o, 1'b0);
    check(ea_o, 16'h00c7);
  endtask : t_refuse

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_inh();
    t_imm_dir();
    t_idx();
    t_ind();
    t_rel();
    t_refuse();
    results();
  end
endmodule : cad_decoder_test

// file: verification/cad_mem_model.sv
// Purpose: Program and data memory seen by the operand-fetch sequencer.
// Assumes: One read strobe per request; the answer comes lat_i cycles later.
// Notes: Outside a valid cycle the data lines show the inverse of the last byte.
module cad_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] lat_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q;
  logic [3:0] cnt;
  logic [7:0] last;

  // Every location gets a filler, its two address bytes XOR a5, so that a wrong address shows up.
  initial
  begin
    for (int i = 0; i < 65536; i++)
    begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      rvalid_o <= 1'b0;
      rdata_o <= 8'h00;
      last <= 8'h00;
      addr_q <= 16'h0000;
    end
    else
    begin
      rvalid_o <= 1'b0;
      rdata_o <= ~last;
      if (rd_i)
      begin
        addr_q <= addr_i;
        cnt <= lat_i;
      end
      else if (cnt == 4'h1)
      begin
        rvalid_o <= 1'b1;
        rdata_o <= mem[addr_q];
        last <= mem[addr_q];
        cnt <= 4'h0;
      end
      else if (cnt != 4'h0)
      begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : cad_mem_model
